/* File: hw/vsd_board_ctl.sv */
// board control: control register, interrupter, bus requester, am code, channels
// assumes host access strobes on clk_i; pins from the bus pass two flip-flops
`timescale 1ns/1ps
`default_nettype none
module vsd_board_ctl (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic        en_i,
    // control register access
    input  wire logic        ctl_wr_i,
    input  wire logic [7:0]  ctl_wdata_i,
    output logic      [7:0]  ctl_rdata_o,
    // dma register access
    input  wire logic        dma_wr_i,
    input  wire logic        dma_ch_i,
    input  wire logic [3:0]  dma_idx_i,
    input  wire logic [15:0] dma_wdata_i,
    output logic      [15:0] dma_rdata_o,
    // transfer engine
    input  wire logic [vsd_pkg::NUM_CH-1:0] xfer_done_i,
    input  wire logic        bus_err_i,
    input  wire logic        addr_err_i,
    output logic      [vsd_pkg::NUM_CH-1:0] busy_o,
    // pins: scsi side
    input  wire logic        scsi_rst_pin_i,
    input  wire logic        scsi_ctrl_irq_i,
    output logic             scsi_rst_o,
    output logic             scsi_rst_oe_o,
    output logic             scsi_ctrl_rst_o,
    // pins: vme interrupter and requester
    input  wire logic        iack_i,
    input  wire logic        bus_grant_i,
    output logic      [7:1]  irq_n_o,
    output logic      [3:0]  br_n_o,
    output logic             bus_own_o,
    output logic      [7:0]  iack_vector_o,
    output logic      [5:0]  am_o,
    output logic             periph_ctl_in_a_o,
    output logic             periph_ctl_in_b_o
);
    import vsd_pkg::*;

    function automatic logic [5:0] fc_to_am(input logic [2:0] fc);
        logic [5:0] am;
        am = 6'h00;
        am[5] = 1'b1;
        am[3] = 1'b1;
        am[2] = fc[2];
        am[4] = (fc[1:0] != 2'h0);
        am[1] = fc[1];
        am[0] = ~fc[1];
        return am;
    endfunction

    logic [7:0] ctl_ff;
    logic [1:0] rst_sync_ff, sirq_sync_ff, iack_sync_ff, bg_sync_ff;
    vsd_irq_type irq_st_ff;
    vsd_brq_type brq_st_ff;
    logic [3:0] rearm_ff;
    logic [7:0] vec_ff;
    logic [5:0] am_ff;

    // two-stage input synchronisers
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_sync_ff  <= 2'h0;
            sirq_sync_ff <= 2'h0;
            iack_sync_ff <= 2'h0;
            bg_sync_ff   <= 2'h0;
        end else if (en_i) begin
            rst_sync_ff  <= {rst_sync_ff[0], scsi_rst_pin_i};
            sirq_sync_ff <= {sirq_sync_ff[0], scsi_ctrl_irq_i};
            iack_sync_ff <= {iack_sync_ff[0], iack_i};
            bg_sync_ff   <= {bg_sync_ff[0], bus_grant_i};
        end
    end
    wire scsi_rst_live = rst_sync_ff[1];
    wire iack_seen     = iack_sync_ff[1];
    wire grant_seen    = bg_sync_ff[1];

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i)
            ctl_ff <= CTL_RESET_VAL;
        else if (en_i && ctl_wr_i)
            ctl_ff <= ctl_wdata_i & CTL_WR_MASK;
    end
    wire [2:0] irq_level  = ctl_ff[CTL_IRQ_MSB:CTL_IRQ_LSB];
    wire       irq_gate   = ctl_ff[CTL_GATE_BIT];
    wire [1:0] brq_level  = ctl_ff[CTL_BRQ_MSB:CTL_BRQ_LSB];
    wire       rst_drive  = ctl_ff[CTL_RST_BIT];

    assign ctl_rdata_o = {scsi_rst_live, 1'b0, ctl_ff[5:0]};
    assign scsi_rst_o      = 1'b1;
    assign scsi_rst_oe_o   = rst_drive;
    assign scsi_ctrl_rst_o = rst_drive || !resetn_i;
    assign periph_ctl_in_b_o = scsi_rst_live;
    assign periph_ctl_in_a_o = sirq_sync_ff[1];

    // channels; channel 0 has higher priority
    logic [NUM_CH-1:0] ch_irq;
    logic [7:0]  ch_vec [NUM_CH];
    logic [2:0]  ch_fc  [NUM_CH];
    logic [15:0] ch_rd  [NUM_CH];
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : gen_ch
            vsd_chan u_chan (
                .clk_i       (clk_i),
                .resetn_i    (resetn_i),
                .en_i        (en_i),
                .wr_i        (dma_wr_i && (dma_ch_i == 1'(g))),
                .idx_i       (dma_idx_i),
                .wdata_i     (dma_wdata_i),
                .rdata_o     (ch_rd[g]),
                .xfer_done_i (xfer_done_i[g]),
                .bus_err_i   (bus_err_i && busy_o[g]),
                .addr_err_i  (addr_err_i && busy_o[g]),
                .preempt_i   ((g != 0) && busy_o[0]),
                .busy_o      (busy_o[g]),
                .irq_o       (ch_irq[g]),
                .vector_o    (ch_vec[g]),
                .fc_o        (ch_fc[g])
            );
        end
    endgenerate
    assign dma_rdata_o = ch_rd[dma_ch_i];
    wire       dma_irq  = |ch_irq;
    wire       sel_hi   = ch_irq[0] || !ch_irq[1];
    wire [7:0] irq_vec  = sel_hi ? ch_vec[0] : ch_vec[1];
    wire       dma_req  = |busy_o;
    wire [2:0] act_fc   = busy_o[0] ? ch_fc[0] : ch_fc[1];

    wire local_irq = dma_irq && irq_gate;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_st_ff <= IRQ_IDLE;
            rearm_ff  <= 4'h0;
            vec_ff    <= 8'h00;
        end else if (en_i) begin
            unique case (irq_st_ff)
                IRQ_IDLE:
                    if (local_irq && irq_level != 3'h0)
                        irq_st_ff <= IRQ_PEND;
                IRQ_PEND:
                    if (iack_seen) begin
                        vec_ff    <= irq_vec;
                        irq_st_ff <= IRQ_REARM;
                        rearm_ff  <= 4'h0;
                    end
                IRQ_REARM:
                    if (local_irq)
                        rearm_ff <= 4'h0;
                    else if (rearm_ff == 4'(IRQ_REARM_CYC - 1))
                        irq_st_ff <= IRQ_IDLE;
                    else
                        rearm_ff <= rearm_ff + 4'h1;
                default:
                    irq_st_ff <= IRQ_IDLE;
            endcase
        end
    end
    assign iack_vector_o = vec_ff;

    always_comb begin
        irq_n_o = 7'h7F;
        if (irq_st_ff == IRQ_PEND && irq_level != 3'h0)
            irq_n_o[irq_level] = 1'b0;
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i)
            brq_st_ff <= BRQ_IDLE;
        else if (en_i) begin
            unique case (brq_st_ff)
                BRQ_IDLE: if (dma_req) brq_st_ff <= BRQ_WAIT;
                BRQ_WAIT: if (!dma_req) brq_st_ff <= BRQ_IDLE;
                          else if (grant_seen) brq_st_ff <= BRQ_OWN;
                BRQ_OWN:  if (!dma_req) brq_st_ff <= BRQ_IDLE;
                default:  brq_st_ff <= BRQ_IDLE;
            endcase
        end
    end
    always_comb begin
        br_n_o = 4'hF;
        if (brq_st_ff == BRQ_WAIT)
            br_n_o[brq_level] = 1'b0;
    end
    assign bus_own_o = (brq_st_ff == BRQ_OWN);

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i)
            am_ff <= 6'h00;
        else if (en_i)
            am_ff <= fc_to_am(act_fc);
    end
    assign am_o = am_ff;
endmodule
`default_nettype wire

/* File: hw/vsd_chan.sv */
// one dma channel register set with start, complete, continue and chain behaviour
// assumes a transfer engine outside that reports operand done and errors
`timescale 1ns/1ps
`default_nettype none
module vsd_chan (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic        en_i,
    // register access
    input  wire logic        wr_i,
    input  wire logic [3:0]  idx_i,
    input  wire logic [15:0] wdata_i,
    output logic      [15:0] rdata_o,
    // transfer engine
    input  wire logic        xfer_done_i,
    input  wire logic        bus_err_i,
    input  wire logic        addr_err_i,
    input  wire logic        preempt_i,
    output logic             busy_o,
    output logic             irq_o,
    output logic       [7:0] vector_o,
    output logic       [2:0] fc_o
);
    import vsd_pkg::*;
    logic [7:0]  ctl_ff, stat_ff, prio_ff, err_ff, niv_ff, eiv_ff, opc_ff, seq_ff, fc_ff;
    logic [15:0] mtc_ff, btc_ff, mar_ff, bar_ff, dar_ff;
    logic        run_ff;
    wire         wr_ctl   = wr_i && idx_i == CH_REG_CTL;
    wire         fault    = bus_err_i || addr_err_i;
    // any channel other than 0 pauses while channel 0 is busy
    wire         step     = run_ff && xfer_done_i && !preempt_i;
    wire         blk_end  = step && mtc_ff == 16'h0001;
    wire [1:0]   chain    = opc_ff[OC_CHAIN_LSB +: 2];
    wire         reload   = blk_end && (ctl_ff[CC_CONT] || (chain == CHAIN_ARRAY && btc_ff != 16'h0000));
    wire         finish   = (blk_end && !reload) || (run_ff && fault);
    wire [15:0]  stride   = opc_ff[OC_WORD] ? 16'h0002 : 16'h0001;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctl_ff <= 8'h00; stat_ff <= 8'h00; prio_ff <= 8'h00; err_ff <= 8'h00;
            opc_ff <= 8'h00; seq_ff <= 8'h00; fc_ff <= 8'h00;
            niv_ff <= VEC_UNINIT; eiv_ff <= VEC_UNINIT;
            mtc_ff <= 16'h0000; btc_ff <= 16'h0000; mar_ff <= 16'h0000;
            bar_ff <= 16'h0000; dar_ff <= 16'h0000; run_ff <= 1'b0;
        end else if (en_i) begin
            if (wr_i) begin
                unique case (idx_i)
                    CH_REG_STAT: stat_ff <= stat_ff & ~wdata_i[7:0];
                    CH_REG_PRIO: prio_ff <= wdata_i[7:0];
                    CH_REG_MTC:  mtc_ff  <= wdata_i;
                    CH_REG_BTC:  btc_ff  <= wdata_i;
                    CH_REG_MAR:  mar_ff  <= wdata_i;
                    CH_REG_BAR:  bar_ff  <= wdata_i;
                    CH_REG_DAR:  dar_ff  <= wdata_i;
                    CH_REG_NIV:  niv_ff  <= wdata_i[7:0];
                    CH_REG_EIV:  eiv_ff  <= wdata_i[7:0];
                    CH_REG_OPC:  opc_ff  <= wdata_i[7:0];
                    CH_REG_SEQ:  seq_ff  <= wdata_i[7:0];
                    CH_REG_FC:   fc_ff   <= wdata_i[7:0];
                    default: ;
                endcase
            end
            if (wr_ctl) begin
                ctl_ff <= wdata_i[7:0];
                if (wdata_i[CC_START] && !run_ff) begin
                    run_ff <= 1'b1;
                    stat_ff[CS_ACTIVE] <= 1'b1;
                end
            end
            if (step) begin
                mtc_ff <= mtc_ff - 16'h0001;
                mar_ff <= seq_ff[1] ? mar_ff - stride : mar_ff + stride;
                if (opc_ff[OC_DUAL])
                    dar_ff <= seq_ff[3] ? dar_ff - stride : dar_ff + stride;
            end
            if (reload) begin
                stat_ff[CS_BLOCK] <= 1'b1;
                if (chain == CHAIN_ARRAY) begin
                    btc_ff <= btc_ff - 16'h0001;
                    bar_ff <= bar_ff + 16'h0002;
                    mar_ff <= bar_ff;
                    mtc_ff <= btc_ff;
                end else begin
                    mtc_ff <= btc_ff;
                    mar_ff <= bar_ff;
                    ctl_ff[CC_CONT] <= 1'b0;
                end
            end
            if (finish) begin
                run_ff <= 1'b0;
                stat_ff[CS_COMPLETE] <= 1'b1;
                stat_ff[CS_ACTIVE] <= 1'b0;
                ctl_ff[CC_START] <= 1'b0;
                if (fault) begin
                    stat_ff[CS_ERROR] <= 1'b1;
                    err_ff <= {6'h00, addr_err_i, bus_err_i};
                end
            end
        end
    end
    assign irq_o    = ctl_ff[CC_INTEN] && stat_ff[CS_COMPLETE];
    assign vector_o = stat_ff[CS_ERROR] ? eiv_ff : niv_ff;
    assign busy_o   = run_ff;
    assign fc_o     = fc_ff[2:0];
    always_comb begin
        unique case (idx_i)
            CH_REG_CTL:  rdata_o = {8'h00, ctl_ff};
            CH_REG_STAT: rdata_o = {8'h00, stat_ff};
            CH_REG_PRIO: rdata_o = {8'h00, prio_ff};
            CH_REG_ERR:  rdata_o = {8'h00, err_ff};
            CH_REG_MTC:  rdata_o = mtc_ff;
            CH_REG_BTC:  rdata_o = btc_ff;
            CH_REG_MAR:  rdata_o = mar_ff;
            CH_REG_BAR:  rdata_o = bar_ff;
            CH_REG_DAR:  rdata_o = dar_ff;
            CH_REG_NIV:  rdata_o = {8'h00, niv_ff};
            CH_REG_EIV:  rdata_o = {8'h00, eiv_ff};
            CH_REG_OPC:  rdata_o = {8'h00, opc_ff};
            CH_REG_SEQ:  rdata_o = {8'h00, seq_ff};
            CH_REG_FC:   rdata_o = {8'h00, fc_ff};
            default:     rdata_o = 16'h0000;
        endcase
    end
endmodule
`default_nettype wire

/* File: hw/vsd_pkg.sv */
// package for the board control block of a bus-to-SCSI dma interface
// assumes one 100 MHz clock domain; shared by the main block and the channel file
package vsd_pkg;
    // control register field positions
    localparam int CTL_IRQ_LSB   = 0;
    localparam int CTL_IRQ_MSB   = 2;
    localparam int CTL_GATE_BIT  = 3;
    localparam int CTL_BRQ_LSB   = 4;
    localparam int CTL_BRQ_MSB   = 5;
    localparam int CTL_SPARE_BIT = 6;
    localparam int CTL_RST_BIT   = 7;
    localparam logic [7:0] CTL_RESET_VAL = 8'h00;
    localparam logic [7:0] CTL_WR_MASK   = 8'hBF;
    // channel register indices (per channel, word wide)
    localparam logic [3:0] CH_REG_CTL    = 4'h0;
    localparam logic [3:0] CH_REG_STAT   = 4'h1;
    localparam logic [3:0] CH_REG_PRIO   = 4'h2;
    localparam logic [3:0] CH_REG_ERR    = 4'h3;
    localparam logic [3:0] CH_REG_MTC    = 4'h4;
    localparam logic [3:0] CH_REG_BTC    = 4'h5;
    localparam logic [3:0] CH_REG_MAR    = 4'h6;
    localparam logic [3:0] CH_REG_BAR    = 4'h7;
    localparam logic [3:0] CH_REG_DAR    = 4'h8;
    localparam logic [3:0] CH_REG_NIV    = 4'h9;
    localparam logic [3:0] CH_REG_EIV    = 4'hA;
    localparam logic [3:0] CH_REG_OPC    = 4'hB;
    localparam logic [3:0] CH_REG_SEQ    = 4'hC;
    localparam logic [3:0] CH_REG_FC     = 4'hD;
    localparam logic [3:0] CH_REG_GEN    = 4'hE;
    // channel control bits
    localparam int CC_START = 7;
    localparam int CC_CONT  = 6;
    localparam int CC_INTEN = 3;
    // channel status bits
    localparam int CS_COMPLETE = 7;
    localparam int CS_BLOCK    = 6;
    localparam int CS_ERROR    = 4;
    localparam int CS_ACTIVE   = 3;
    // operation control: chain mode field and size
    localparam int OC_CHAIN_LSB = 2;
    localparam logic [1:0] CHAIN_NONE  = 2'h0;
    localparam logic [1:0] CHAIN_ARRAY = 2'h2;
    localparam int OC_DUAL = 7;
    localparam int OC_WORD = 4;
    localparam logic [7:0] VEC_UNINIT = 8'h0F;
    // interrupter re-arm wait: 125 ns of negated local request
    localparam int IRQ_REARM_NS  = 125;
    localparam int CLK_PERIOD_NS = 10;
    localparam int IRQ_REARM_CYC = (IRQ_REARM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int NUM_CH = 2;
    typedef enum logic [1:0] {BRQ_IDLE, BRQ_WAIT, BRQ_OWN} vsd_brq_type;
    typedef enum logic [1:0] {IRQ_IDLE, IRQ_PEND, IRQ_REARM} vsd_irq_type;
endpackage

/* File: tb/vsd_board_ctl_monitor.sv */
// port checker for the board control block
// assumes one clock domain; bound into every instance of the block
`timescale 1ns/1ps
`default_nettype none
module vsd_board_ctl_monitor (
    input wire logic       clk_i,
    input wire logic       resetn_i,
    input wire logic       ctl_wr_i,
    input wire logic [7:0] ctl_wdata_i,
    input wire logic [7:0] ctl_rdata_o,
    input wire logic       scsi_rst_pin_i,
    input wire logic       scsi_rst_oe_o,
    input wire logic       periph_ctl_in_b_o,
    input wire logic       iack_i,
    input wire logic       bus_grant_i,
    input wire logic [7:1] irq_n_o,
    input wire logic [3:0] br_n_o,
    input wire logic       bus_own_o,
    input wire logic [5:0] am_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);
    sequence s_req;
        (br_n_o != 4'hF) ##1 bus_grant_i [*3];
    endsequence
    sequence s_ack;
        (irq_n_o != 7'h7F) ##1 iack_i [*4];
    endsequence
    reset_clear_a: assert property (disable iff (1'b0)
        !resetn_i |-> ctl_rdata_o[5:0] == 6'h00 && irq_n_o == 7'h7F && br_n_o == 4'hF && !bus_own_o)
        else $error("outputs not cleared in reset");
    irq_level_a: assert property ((irq_n_o != 7'h7F) |->
        ctl_rdata_o[2:0] != 3'h0 && irq_n_o == ~(7'h01 << (ctl_rdata_o[2:0] - 3'h1)))
        else $error("interrupt line does not match level");
    br_level_a: assert property ((br_n_o != 4'hF) |-> br_n_o == ~(4'h1 << ctl_rdata_o[5:4]))
        else $error("bus request line does not match level");
    spare_zero_a: assert property (ctl_rdata_o[6] == 1'b0)
        else $error("spare bit reads one");
    drive_follow_a: assert property (ctl_wr_i |=> scsi_rst_oe_o == $past(ctl_wdata_i[7]))
        else $error("reset drive not taken from write");
    rst_read_a: assert property ($rose(scsi_rst_pin_i) |-> ##[1:3] ctl_rdata_o[7])
        else $error("reset line not seen in bit 7");
    periph_b_a: assert property (periph_ctl_in_b_o == $past(scsi_rst_pin_i, 2))
        else $error("second peripheral input not the reset line");
    am_code_a: assert property (bus_own_o |-> am_o[5] && am_o[3] && am_o[0] == !am_o[1]
        && (!am_o[1] || am_o[4])) else $error("illegal address modifier");
    own_grant_a: assert property (s_req |-> ##[0:2] bus_own_o)
        else $error("grant not taken");
    ack_release_a: assert property (s_ack |-> ##[0:3] irq_n_o == 7'h7F)
        else $error("interrupt line held after acknowledge");
endmodule
bind vsd_board_ctl vsd_board_ctl_monitor u_mon (.clk_i(clk_i), .resetn_i(resetn_i),
    .ctl_wr_i(ctl_wr_i), .ctl_wdata_i(ctl_wdata_i), .ctl_rdata_o(ctl_rdata_o),
    .scsi_rst_pin_i(scsi_rst_pin_i), .scsi_rst_oe_o(scsi_rst_oe_o),
    .periph_ctl_in_b_o(periph_ctl_in_b_o), .iack_i(iack_i), .bus_grant_i(bus_grant_i),
    .irq_n_o(irq_n_o), .br_n_o(br_n_o), .bus_own_o(bus_own_o), .am_o(am_o));
`default_nettype wire

/* File: tb/vsd_board_ctl_test.sv */
// testbench: control register, reset line, and one transfer per level code
// assumes the bus model grants and acknowledges on its own
`timescale 1ns/1ps
`default_nettype none
module vsd_board_ctl_test;
    import vsd_pkg::*;
    logic        clk_i = 1'b1;
    logic        resetn_i = 1'b1;
    logic        ctl_wr_i = 1'b0;
    logic [7:0]  ctl_wdata_i = 8'h00;
    logic        dma_wr_i = 1'b0;
    logic [3:0]  dma_idx_i = 4'h0;
    logic [15:0] dma_wdata_i = 16'h0000;
    logic [1:0]  xfer_done_i = 2'h0;
    logic        bus_err_i = 1'b0;
    logic        scsi_ctrl_irq_i = 1'b0;
    logic        ext_rst = 1'b0;
    logic        ch = 1'b0;
    logic [7:0]  ctl_rdata_o, iack_vector_o;
    logic [15:0] dma_rdata_o, d;
    logic [1:0]  busy_o;
    logic [7:1]  irq_n_o;
    logic [3:0]  br_n_o;
    logic [5:0]  am_o;
    logic        rst_o, rst_oe, ctl_rst, own, pa, pb, iack, grant;
    logic [2:0]  lv;
    int          n_fail = 0;
    int          checked = 0;
    int          i, k;
    wire logic   pin = (rst_oe & rst_o) | ext_rst;
    vsd_board_ctl dut (.clk_i(clk_i), .resetn_i(resetn_i), .en_i(1'b1),
        .ctl_wr_i(ctl_wr_i), .ctl_wdata_i(ctl_wdata_i), .ctl_rdata_o(ctl_rdata_o),
        .dma_wr_i(dma_wr_i), .dma_ch_i(ch), .dma_idx_i(dma_idx_i),
        .dma_wdata_i(dma_wdata_i), .dma_rdata_o(dma_rdata_o), .xfer_done_i(xfer_done_i),
        .bus_err_i(bus_err_i), .addr_err_i(1'b0), .busy_o(busy_o), .scsi_rst_pin_i(pin),
        .scsi_ctrl_irq_i(scsi_ctrl_irq_i), .scsi_rst_o(rst_o), .scsi_rst_oe_o(rst_oe),
        .scsi_ctrl_rst_o(ctl_rst), .iack_i(iack), .bus_grant_i(grant), .irq_n_o(irq_n_o),
        .br_n_o(br_n_o), .bus_own_o(own), .iack_vector_o(iack_vector_o), .am_o(am_o),
        .periph_ctl_in_a_o(pa), .periph_ctl_in_b_o(pb));
    vsd_vme_model #(.DLY(6)) u_vme (.clk_i(clk_i), .resetn_i(resetn_i), .br_n_i(br_n_o),
        .irq_n_i(irq_n_o), .busy_i(|busy_o), .grant_o(grant), .iack_o(iack));
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic ctl_wr(input logic [7:0] v);
        @(negedge clk_i);
        ctl_wr_i = 1'b1;
        ctl_wdata_i = v;
        @(negedge clk_i);
        ctl_wr_i = 1'b0;
    endtask
    task automatic dma_wr(input logic [3:0] idx, input logic [15:0] v);
        @(negedge clk_i);
        dma_wr_i = 1'b1;
        dma_idx_i = idx;
        dma_wdata_i = v;
        @(negedge clk_i);
        dma_wr_i = 1'b0;
    endtask
    task automatic dma_rd(input logic [3:0] idx);
        @(negedge clk_i);
        dma_idx_i = idx;
        #1 d = dma_rdata_o;
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        #100000;
        n_fail++;
        stop_test();
    end
    initial begin
        // first edge is a falling one, so reset is in before any rising edge
        @(negedge clk_i);
        resetn_i = 1'b0;
        repeat (10) @(negedge clk_i);
        resetn_i = 1'b1;
        @(negedge clk_i);
        check({8'h00, ctl_rdata_o}, 16'h0000);
        check({2'h0, irq_n_o, br_n_o, own, busy_o}, 16'h3FF8);
        dma_rd(CH_REG_NIV);
        check(d, 16'h000F);
        dma_rd(CH_REG_CTL);
        check(d, 16'h0000);
        ctl_wr(8'hFF);
        repeat (4) @(negedge clk_i);
        check({8'h00, ctl_rdata_o}, 16'h00BF);
        check({13'h0, rst_oe, ctl_rst, pb}, 16'h0007);
        ctl_wr(8'h00);
        ext_rst = 1'b1;
        scsi_ctrl_irq_i = 1'b1;
        repeat (4) @(negedge clk_i);
        check({7'h00, pa, ctl_rdata_o}, 16'h0180);
        ext_rst = 1'b0;
        scsi_ctrl_irq_i = 1'b0;
        dma_wr(CH_REG_MTC, 16'hFFFF);
        dma_rd(CH_REG_MTC);
        check(d, 16'hFFFF);
        for (i = 0; i < 8; i++) begin
            lv = i[2:0];
            ctl_wr({2'b00, lv[1:0], i != 5, lv});
            dma_wr(CH_REG_FC, {5'h00, lv, 1'b0, lv, 1'b0, lv});
            dma_wr(CH_REG_MTC, 16'h0001);
            dma_wr(CH_REG_NIV, {8'h00, 5'h08, lv});
            dma_wr(CH_REG_EIV, 16'h00E0);
            dma_wr(CH_REG_CTL, 16'h0088);
            for (k = 0; k < 20 && br_n_o === 4'hF; k++) @(negedge clk_i);
            check({12'h000, br_n_o}, {12'h000, ~(4'h1 << lv[1:0])});
            for (k = 0; k < 50 && own !== 1'b1; k++) @(negedge clk_i);
            check({10'h000, am_o}, {10'h000, 1'b1, |lv[1:0], 1'b1, lv[2], lv[1], ~lv[1]});
            @(negedge clk_i);
            if (i == 7) bus_err_i = 1'b1;
            else xfer_done_i = 2'b01;
            @(negedge clk_i);
            bus_err_i = 1'b0;
            xfer_done_i = 2'b00;
            for (k = 0; k < 20 && busy_o[0] !== 1'b0; k++) @(negedge clk_i);
            dma_rd(CH_REG_STAT);
            check(d & 16'h0090, (i == 7) ? 16'h0090 : 16'h0080);
            if (lv != 3'h0 && i != 5) begin
                for (k = 0; k < 20 && irq_n_o === 7'h7F; k++) @(negedge clk_i);
                check({9'h000, irq_n_o}, {9'h000, ~(7'h01 << (lv - 3'h1))});
                for (k = 0; k < 40 && irq_n_o !== 7'h7F; k++) @(negedge clk_i);
                check({8'h00, iack_vector_o}, (i == 7) ? 16'h00E0 : {8'h00, 5'h08, lv});
            end else begin
                repeat (20) @(negedge clk_i);
                check({9'h000, irq_n_o}, 16'h007F);
            end
            dma_wr(CH_REG_STAT, 16'h00FF);
            ctl_wr(8'h00);
            repeat (20) @(negedge clk_i);
        end
        // channel 1 holds its count while channel 0 runs, then resumes
        ch = 1'b1;
        dma_wr(CH_REG_MTC, 16'h0002);
        dma_wr(CH_REG_CTL, 16'h0080);
        ch = 1'b0;
        dma_wr(CH_REG_MTC, 16'h0002);
        dma_wr(CH_REG_CTL, 16'h0080);
        @(negedge clk_i);
        xfer_done_i = 2'b11;
        @(negedge clk_i);
        xfer_done_i = 2'b00;
        ch = 1'b1;
        dma_rd(CH_REG_MTC);
        check(d, 16'h0002);
        @(negedge clk_i);
        xfer_done_i = 2'b11;
        @(negedge clk_i);
        xfer_done_i = 2'b10;
        @(negedge clk_i);
        xfer_done_i = 2'b00;
        dma_rd(CH_REG_MTC);
        check(d, 16'h0001);
        stop_test();
    end
endmodule
`default_nettype wire

/* File: tb/vsd_vme_model.sv */
// bus side model: arbiter granting requests, handler acknowledging interrupts
// assumes active low request lines and a level that is high while the bus is used
`timescale 1ns/1ps
`default_nettype none
module vsd_vme_model #(
    parameter int DLY = 6
) (
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    input  wire logic [3:0] br_n_i,
    input  wire logic [7:1] irq_n_i,
    input  wire logic       busy_i,
    output logic            grant_o,
    output logic            iack_o
);
    int gcnt;
    int icnt;
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            gcnt <= 0;
            grant_o <= 1'b0;
        end else if (br_n_i != 4'hF) begin
            gcnt <= gcnt + 1;
            if (gcnt >= DLY) grant_o <= 1'b1;
        end else begin
            gcnt <= 0;
            if (!busy_i) grant_o <= 1'b0;
        end
    end
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            icnt <= 0;
            iack_o <= 1'b0;
        end else if (irq_n_i != 7'h7F) begin
            icnt <= icnt + 1;
            if (icnt >= DLY) iack_o <= 1'b1;
        end else begin
            icnt <= 0;
            iack_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire
